// ### design/rcf_pkg.sv
// constants and register map of the reset-cause flag block
// Functional notes
// - stack overflow sets bit 7; it holds until firmware writes zero or a power-on or brown-out clears it.
// - stack underflow sets bit 6; it holds until firmware writes zero or a power-on or brown-out clears it.
// - bit 5 is unimplemented, reads zero, and ignores writes.
// - watchdog reset clears bit 4; firmware may write one to rearm it.
// - external clear pin reset clears bit 3; firmware may write it back to one.
// - reset instruction clears bit 2; it reads one otherwise or after a one is written.
// - power-on reset clears bit 1; firmware writes one to detect the next one.
// - brown-out reset clears bit 0; firmware sets it after power-on or brown-out.
// - power-on or brown-out loads stack flags 0, bits 4 to 2 with 1; other resets keep both status bits.
package rcf_pkg;

    // register bus
    localparam int RCF_AW = 4;
    localparam int RCF_DW = 8;

    // register offsets
    localparam logic [RCF_AW-1:0] RCF_OFS_CAUSE = 4'h0;
    localparam logic [RCF_AW-1:0] RCF_OFS_STATUS = 4'h1;
    localparam logic [RCF_AW-1:0] RCF_OFS_MASK = 4'h2;

    // reset_cause_register field positions
    localparam int RCF_B_STK_OVF = 7;
    localparam int RCF_B_STK_UNF = 6;
    localparam int RCF_B_UNUSED = 5;
    localparam int RCF_B_WDT = 4;
    localparam int RCF_B_PIN = 3;
    localparam int RCF_B_OPCODE = 2;
    localparam int RCF_B_POR = 1;
    localparam int RCF_B_BROWNOUT = 0;

    // implemented bits of reset_cause_register
    localparam logic [RCF_DW-1:0] RCF_CAUSE_IMPL = 8'hdf;

    // value loaded by a power-on or brown-out: stack flags 0, cause flags 1
    localparam logic [RCF_DW-1:0] RCF_CAUSE_INIT = 8'h1c;
    // bits that a power-on or brown-out loads from the init value
    localparam logic [RCF_DW-1:0] RCF_CAUSE_INIT_MASK = 8'hdc;
    // value after the block's own asynchronous reset (a power-on)
    localparam logic [RCF_DW-1:0] RCF_CAUSE_RST = 8'h1c;

    // event status / mask field positions
    localparam int RCF_NEV = 7;
    localparam int RCF_E_STK_OVF = 6;
    localparam int RCF_E_STK_UNF = 5;
    localparam int RCF_E_WDT = 4;
    localparam int RCF_E_PIN = 3;
    localparam int RCF_E_OPCODE = 2;
    localparam int RCF_E_POR = 1;
    localparam int RCF_E_BROWNOUT = 0;

    localparam logic [RCF_NEV-1:0] RCF_STATUS_RST = 7'h00;
    localparam logic [RCF_NEV-1:0] RCF_MASK_RST = 7'h00;
    localparam logic [RCF_DW-1:0] RCF_RDATA_IDLE = 8'h00;

    typedef logic [RCF_NEV-1:0] rcf_events_t;

endpackage

// ### design/rcf_event_status.sv
// sticky event status with clear-on-read, mask and level interrupt
`timescale 1ns/10ps
module rcf_event_status (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // events
    input wire rcf_pkg::rcf_events_t events,
    // register access
    input wire logic status_rd,
    input wire logic mask_wr,
    input wire rcf_pkg::rcf_events_t mask_wdata,
    // state
    output rcf_pkg::rcf_events_t status_q,
    output rcf_pkg::rcf_events_t mask_q,
    output logic irq
);
    import rcf_pkg::*;

    rcf_events_t status_d;
    rcf_events_t mask_d;

    // a read clears, but an event in the same cycle survives the clear
    assign status_d = (status_rd ? RCF_STATUS_RST : status_q) | events;
    assign mask_d = mask_wr ? mask_wdata : mask_q;
    assign irq = |(status_q & mask_q);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_q <= RCF_STATUS_RST;
            mask_q <= RCF_MASK_RST;
        end else begin
            status_q <= status_d;
            mask_q <= mask_d;
        end
    end

endmodule // rcf_event_status

// ### design/rcf_reset_cause.sv
// reset-cause flag register with event status and register port
`timescale 1ns/10ps
module rcf_reset_cause (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // reset and stack events from the reset logic, one-cycle pulses
    input wire logic stack_overflow_event,
    input wire logic stack_underflow_event,
    input wire logic watchdog_reset_event,
    input wire logic pin_reset_event,
    input wire logic reset_opcode_event,
    input wire logic power_on_event,
    input wire logic brownout_event,
    // register port
    input wire logic [rcf_pkg::RCF_AW-1:0] addr,
    input wire logic [rcf_pkg::RCF_DW-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [rcf_pkg::RCF_DW-1:0] rdata,
    // flag view and interrupt
    output logic [rcf_pkg::RCF_DW-1:0] reset_cause_register,
    output logic irq
);
    import rcf_pkg::*;

    // next value of one flag: hardware set, then hardware clear, then firmware write
    function automatic logic flag_next(
        input logic cur,
        input logic hw_set,
        input logic hw_clr,
        input logic fw_wr,
        input logic fw_bit
    );
        logic res;
        res = cur;
        if (hw_set) begin
            res = 1'b1;
        end else if (hw_clr) begin
            res = 1'b0;
        end else if (fw_wr) begin
            res = fw_bit;
        end
        return res;
    endfunction

    // register decode
    wire sel_cause;
    wire sel_status;
    wire sel_mask;
    wire cause_wr;
    wire mask_wr;
    wire status_rd;

    assign sel_cause = (addr == RCF_OFS_CAUSE);
    assign sel_status = (addr == RCF_OFS_STATUS);
    assign sel_mask = (addr == RCF_OFS_MASK);
    assign cause_wr = wr_en & sel_cause;
    assign mask_wr = wr_en & sel_mask;
    assign status_rd = rd_en & sel_status;

    // power-on and brown-out both reload the two stack flags and the three cause flags
    wire full_init;
    assign full_init = power_on_event | brownout_event;

    // hardware set and clear terms for each bit
    logic [RCF_DW-1:0] hw_set;
    logic [RCF_DW-1:0] hw_clr;

    always_comb begin
        hw_set = '0;
        hw_clr = '0;
        // stack flags are set by their stack fault
        hw_set[RCF_B_STK_OVF] = stack_overflow_event & ~full_init;
        hw_set[RCF_B_STK_UNF] = stack_underflow_event & ~full_init;
        // cause flags are cleared by the reset they name
        hw_clr[RCF_B_WDT] = watchdog_reset_event & ~full_init;
        hw_clr[RCF_B_PIN] = pin_reset_event & ~full_init;
        hw_clr[RCF_B_OPCODE] = reset_opcode_event & ~full_init;
        // power-on clears both status bits, brown-out only its own
        hw_clr[RCF_B_POR] = power_on_event;
        hw_clr[RCF_B_BROWNOUT] = power_on_event | brownout_event;
        // power-on or brown-out loads the init value into the five flags
        if (full_init) begin
            hw_set = hw_set | (RCF_CAUSE_INIT & RCF_CAUSE_INIT_MASK);
            hw_clr = hw_clr | (~RCF_CAUSE_INIT & RCF_CAUSE_INIT_MASK);
        end
    end

    // flag register
    logic [RCF_DW-1:0] cause_q;
    logic [RCF_DW-1:0] cause_d;

    always_comb begin
        cause_d = '0;
        for (int i = 0; i < RCF_DW; i++) begin
            cause_d[i] = flag_next(cause_q[i], hw_set[i], hw_clr[i], cause_wr, wdata[i]);
        end
        // the unimplemented bit never stores anything
        cause_d[RCF_B_UNUSED] = 1'b0;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cause_q <= RCF_CAUSE_RST;
        end else begin
            cause_q <= cause_d & RCF_CAUSE_IMPL;
        end
    end

    assign reset_cause_register = cause_q;

    // event status, mask and interrupt
    rcf_events_t events;
    rcf_events_t status_q;
    rcf_events_t mask_q;

    always_comb begin
        events = '0;
        events[RCF_E_STK_OVF] = stack_overflow_event;
        events[RCF_E_STK_UNF] = stack_underflow_event;
        events[RCF_E_WDT] = watchdog_reset_event;
        events[RCF_E_PIN] = pin_reset_event;
        events[RCF_E_OPCODE] = reset_opcode_event;
        events[RCF_E_POR] = power_on_event;
        events[RCF_E_BROWNOUT] = brownout_event;
    end

    rcf_event_status u_status (
        .clk(clk),
        .resetn(resetn),
        .events(events),
        .status_rd(status_rd),
        .mask_wr(mask_wr),
        .mask_wdata(wdata[RCF_NEV-1:0]),
        .status_q(status_q),
        .mask_q(mask_q),
        .irq(irq)
    );

    // read mux, unmapped offsets read zero
    logic [RCF_DW-1:0] rd_mux;

    always_comb begin
        rd_mux = RCF_RDATA_IDLE;
        if (sel_cause) begin
            rd_mux = cause_q & RCF_CAUSE_IMPL;
        end else if (sel_status) begin
            rd_mux = {1'b0, status_q};
        end else if (sel_mask) begin
            rd_mux = {1'b0, mask_q};
        end
    end

    // read data stand only in the cycle after the read strobe
    logic [RCF_DW-1:0] rdata_q;
    logic [RCF_DW-1:0] rdata_d;

    assign rdata_d = rd_en ? rd_mux : RCF_RDATA_IDLE;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= RCF_RDATA_IDLE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;

endmodule // rcf_reset_cause

// ### verif/rcf_reset_cause_chk.sv
// assertions on the reset-cause flag block and their bind
`timescale 1ns/10ps
module rcf_reset_cause_chk (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // events
    input wire logic stack_overflow_event,
    input wire logic stack_underflow_event,
    input wire logic watchdog_reset_event,
    input wire logic pin_reset_event,
    input wire logic reset_opcode_event,
    input wire logic power_on_event,
    input wire logic brownout_event,
    // register port
    input wire logic [rcf_pkg::RCF_AW-1:0] addr,
    input wire logic [rcf_pkg::RCF_DW-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [rcf_pkg::RCF_DW-1:0] rdata,
    // flags
    input wire logic [rcf_pkg::RCF_DW-1:0] reset_cause_register,
    input wire logic irq
);
    import rcf_pkg::*;
    wire pb = power_on_event | brownout_event;
    wire cw = wr_en && addr == RCF_OFS_CAUSE;
    wire [RCF_DW-1:0] cr = reset_cause_register;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_ovf; stack_overflow_event && !pb |=> cr[7]; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag not set");
    property p_unf; stack_underflow_event && !pb |=> cr[6]; endproperty
    a_unf: assert property (p_unf) else $error("underflow flag not set");
    property p_b5; cr[5] == 1'b0; endproperty
    a_b5: assert property (p_b5) else $error("bit 5 not zero");
    property p_wdt; watchdog_reset_event && !pb |=> !cr[4]; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog flag not cleared");
    property p_pin; pin_reset_event && !pb |=> !cr[3]; endproperty
    a_pin: assert property (p_pin) else $error("pin flag not cleared");
    property p_op; reset_opcode_event && !pb |=> !cr[2]; endproperty
    a_op: assert property (p_op) else $error("opcode flag not cleared");
    property p_por; power_on_event |=> cr == 8'h1c; endproperty
    a_por: assert property (p_por) else $error("power-on load wrong");
    property p_brownout;
        brownout_event && !power_on_event && !cw |=> cr == {6'h07, $past(cr[1]), 1'b0};
    endproperty
    a_brownout: assert property (p_brownout) else $error("brown-out load wrong");
    c_por: cover property (power_on_event);
    c_wr: cover property (cw && watchdog_reset_event);
    c_irq: cover property (irq);
endmodule // rcf_reset_cause_chk

bind rcf_reset_cause rcf_reset_cause_chk rcf_reset_cause_chk_i (.clk, .resetn,
    .stack_overflow_event, .stack_underflow_event, .watchdog_reset_event,
    .pin_reset_event, .reset_opcode_event, .power_on_event, .brownout_event,
    .addr, .wdata, .wr_en, .rd_en, .rdata, .reset_cause_register, .irq);

// ### verif/rcf_src_model.sv
// model of the reset logic that pulses the event inputs
`timescale 1ns/10ps
module rcf_src_model (
    // clock
    input wire logic clk,
    // events: ovf unf wdt pin opcode power-on brownout
    output logic [6:0] ev
);
    initial ev = 7'h00;
    task automatic pulse(input logic [6:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 7'h00;
    endtask
endmodule // rcf_src_model

// ### verif/tb_rcf_reset_cause.sv
// testbench of the reset-cause flag block
`timescale 1ns/10ps
module tb_rcf_reset_cause;
    import rcf_pkg::*;
    logic clk, resetn, wr_en, rd_en, irq;
    logic [RCF_AW-1:0] addr;
    logic [RCF_DW-1:0] wdata, rdata, rcr;
    logic [6:0] ev;
    logic [6:0] m [7] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h01, 7'h02};
    logic [7:0] x [7] = '{8'h9f, 8'hdf, 8'hcf, 8'hc7, 8'hc3, 8'h1e, 8'h1c};
    int n_errors = 0;
    int n_tests = 0;
    rcf_src_model rcf_src_model_i (.clk(clk), .ev(ev));
    rcf_reset_cause rcf_reset_cause_i (.clk(clk), .resetn(resetn),
        .stack_overflow_event(ev[6]), .stack_underflow_event(ev[5]),
        .watchdog_reset_event(ev[4]), .pin_reset_event(ev[3]),
        .reset_opcode_event(ev[2]), .power_on_event(ev[1]),
        .brownout_event(ev[0]), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .reset_cause_register(rcr), .irq(irq));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string s);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(s, e, rdata);
    endtask
    task automatic report_and_stop;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        resetn = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rd(4'h0, 8'h1c, "cause init");
        rd(4'h1, 8'h00, "status init");
        wr(4'h2, 8'h7f);
        rd(4'h2, 8'h7f, "mask");
        wr(4'h0, 8'hff);
        rd(4'h0, 8'hdf, "cause ff");
        wr(4'h0, 8'h5f);
        rd(4'h0, 8'h5f, "cause 5f");
        wr(4'h0, 8'h1f);
        for (int i = 0; i < 7; i++) begin
            rcf_src_model_i.pulse(m[i]);
            rd(4'h0, x[i], "cause event");
        end
        chk("irq on", 8'h01, {7'h00, irq});
        rd(4'h1, 8'h7f, "status");
        chk("irq off", 8'h00, {7'h00, irq});
        wr(4'h0, 8'h1f);
        rd(4'h0, 8'h1f, "rearm");
        wr(4'h2, 8'h00);
        rcf_src_model_i.pulse(7'h40);
        #1;
        chk("irq masked", 8'h00, {7'h00, irq});
        rd(4'h1, 8'h40, "status masked");
        fork
            wr(4'h0, 8'h1f);
            rcf_src_model_i.pulse(7'h10);
        join
        rd(4'h0, 8'h0f, "event beats write");
        wr(4'hf, 8'hff);
        rd(4'hf, 8'h00, "unmapped");
        rd(4'h0, 8'h0f, "cause kept");
        chk("flag view", 8'h0f, rcr);
        @(posedge clk);
        #1;
        chk("rdata idle", 8'h00, rdata);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(4'h0, 8'h1c, "cause after reset");
        rd(4'h1, 8'h00, "status after reset");
        chk("flag view reset", 8'h1c, rcr);
        chk("irq after reset", 8'h00, {7'h00, irq});
        report_and_stop();
    end
endmodule // tb_rcf_reset_cause
